//--- common/debug_bkpt_map.vh
`ifndef DEBUG_BKPT_MAP_VH
`define DEBUG_BKPT_MAP_VH
`define REG_COMMAND_WORD   16'hFF00
`define REG_STATUS         16'hFF01
`define REG_SHIFT_HI       16'hFF02
`define REG_SHIFT_LO       16'hFF03
`define REG_ADDR_HI        16'hFF04
`define REG_ADDR_LO        16'hFF05
`define REG_SAVED_CCR      16'hFF06
`define DEBUG_MAP_BASE_HI  8'hFF
`define ST_PERMIT_BIT      7
`define ST_ACTIVE_BIT      6
`define ST_TAG_BIT         5
`define ST_SHIFT_VALID_BIT 4
`define ST_STEP_BIT        3
`define STATUS_WMASK       8'hF8
`define STATUS_RESET       8'h00
`define CMD_HW_BIT         7
`define CMD_DATA_BIT       6
`define CMD_READ_BIT       5
`define CMD_ENTER_BACKGROUND_REQUEST_BIT      4
`define CMD_WORD_BIT       3
`define CMD_MAP_BIT        2
`define CMD_FLOW_HI        4
`define CMD_FLOW_LO        3
`define CMD_REG_HI         2
`define CMD_REG_LO         0
`define CMD_BACKGROUND     8'h90
`define FLOW_NONE          2'b00
`define FLOW_GO            2'b01
`define FLOW_STEP          2'b10
`define FLOW_TAG_GO        2'b11
`define REGSEL_NEXT        3'b010
`define REGSEL_PC          3'b011
`define MODE_OFF           2'b00
`define MODE_SWI_DUAL      2'b01
`define MODE_BDM_FULL      2'b10
`define MODE_BDM_DUAL      2'b11
`define IDLE_TIMEOUT_CYC   10'd512
`endif

//--- hw/debug_breakpoint_core.v
// Summary of operation
// - Command word bit 7 reads 1 for hardware commands, 0 for firmware.
// - Command word data flag is 1 when command carries a data word.
// - Command word direction flag is 1 for read, 0 for write.
// - Background-request bit flags hardware background command; whole word is 90h.
// - Hardware size flag selects byte when 0, word when 1.
// - Map flag maps debug registers and ROM at FF00-FFFF during hardware access.
// - Firmware flow field: 01 resume, 10 single step, 11 tag and resume.
// - Register select 010 is pre-increment-X next word, 011 is program counter.
// - Status bit 7 permits background entry; hardware commands accepted unless tagging is set.
// - Status bit 6 is 1 while background mode is active.
// - Tagging bit set by tag-and-go, cleared on entry; blocks serial commands.
// - Shift-valid status bit and single-step status bit are kept.
// - Status resets to zero, bits 2..0 read zero, writable by commands/firmware.
// - Sixteen-bit shift word is readable and writable in all modes.
// - Sixteen-bit address hold is readable always, written only by debug hardware.
// - Condition codes are saved on background entry; firmware may overwrite.
// - A match enters background mode or raises software interrupt per mode.
// - No breakpoint fires while background mode is active.
// - Interrupt dual mode uses fetch tagging; direction and masks ignored.
// - In dual modes data-compare enable arms second address break; masks ignored.
// - Full mode ignores second range/direction; program break ignores data and masks.
// - Debug dual mode obeys program, range and direction controls per breakpoint.
// - Mode bits: 00 off, 01 interrupt dual, 10 full, 11 debug dual.
// - Command word clears after 512 cycles between host falling edges.
`timescale 1ns/1ps
`include "debug_bkpt_map.vh"
module debug_breakpoint_core (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        host_line,
    input  wire        cmd_load,
    input  wire [7:0]  cmd_code,
    input  wire        shift_load,
    input  wire [15:0] shift_in,
    input  wire        shift_done,
    input  wire        addr_load,
    input  wire [15:0] addr_in,
    input  wire        enter_background,
    input  wire        exit_background,
    input  wire [7:0]  cpu_ccr,
    input  wire        reg_sel,
    input  wire        reg_write,
    input  wire [2:0]  reg_index,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    input  wire [15:0] bus_addr,
    input  wire [15:0] bus_data,
    input  wire        bus_read,
    input  wire        bus_valid,
    input  wire        bus_fetch,
    input  wire [1:0]  break_mode,
    input  wire        program_address_break,
    input  wire        first_low_range_enable,
    input  wire        second_low_range_enable,
    input  wire        data_compare_enable,
    input  wire        high_byte_mask,
    input  wire        low_byte_mask,
    input  wire        direction_match_value,
    input  wire        direction_match_enable,
    input  wire        second_direction_value,
    input  wire        second_direction_enable,
    input  wire [15:0] break_addr_value,
    input  wire [15:0] break_data_value,
    output wire        hw_command,
    output wire        has_data,
    output wire        is_read,
    output wire        enter_background_request,
    output wire        word_transfer,
    output wire        debug_map_select,
    output wire [1:0]  flow_control_field,
    output wire [2:0]  target_register_field,
    output wire        resume_cmd,
    output wire        single_step_cmd,
    output wire        tag_and_resume_cmd,
    output wire        read_write_next,
    output wire        select_pc,
    output wire        debug_map_active,
    output wire        background_grant,
    output wire        command_accept,
    output wire        debug_permit,
    output wire        debug_active_flag,
    output wire        tagging_enable,
    output wire        shift_valid,
    output reg         break_to_background,
    output reg         break_to_interrupt,
    output reg         break_tag_fetch
);
    reg  [7:0]  debug_command_word;
    reg  [7:0]  debug_status;
    reg  [15:0] debug_shift_word;
    reg  [15:0] debug_address_hold;
    reg  [7:0]  saved_condition_codes;
    reg         line_sync1;
    reg         line_sync2;
    reg         line_prev;
    reg  [9:0]  idle_count;
    reg  [7:0]  next_status;
    wire        host_fall;
    wire        status_wr;
    wire        entering;

    // Byte-lane compare with optional don't-care, reused by the address and data comparators.
    function byte_hit;
        input [7:0] a;
        input [7:0] b;
        input       care;
        begin
            byte_hit = !care || (a == b);
        end
    endfunction

    function dir_hit;
        input rd;
        input val;
        input en;
        begin
            dir_hit = !en || (rd == val);
        end
    endfunction

    // Host line is asynchronous; only the second stage and its one-cycle delayed copy feed logic.
    always @(posedge clk) begin
        if (!reset_n) begin
            line_sync1 <= 1'b1;
            line_sync2 <= 1'b1;
            line_prev  <= 1'b1;
        end else begin
            line_sync1 <= host_line;
            line_sync2 <= line_sync1;
            line_prev  <= line_sync2;
        end
    end
    assign host_fall = line_prev && !line_sync2;

    always @(posedge clk) begin
        if (!reset_n) begin
            idle_count <= 10'd0;
        end else if (host_fall) begin
            idle_count <= 10'd0;
        end else if (idle_count != `IDLE_TIMEOUT_CYC) begin
            idle_count <= idle_count + 10'd1;
        end
    end

    // The timeout clear loses to a freshly shifted command so none is dropped.
    always @(posedge clk) begin
        if (!reset_n) begin
            debug_command_word <= 8'h00;
        end else if (cmd_load) begin
            debug_command_word <= cmd_code;
        end else if (reg_sel && reg_write && reg_index == 3'd0) begin
            debug_command_word <= reg_wdata;
        end else if (idle_count == `IDLE_TIMEOUT_CYC - 10'd1 && !host_fall) begin
            debug_command_word <= 8'h00;
        end
    end

    assign hw_command               = debug_command_word[`CMD_HW_BIT];
    assign has_data                 = debug_command_word[`CMD_DATA_BIT];
    assign is_read                  = debug_command_word[`CMD_READ_BIT];
    assign enter_background_request = hw_command &&
                                      debug_command_word[`CMD_ENTER_BACKGROUND_REQUEST_BIT] &&
                                      debug_command_word == `CMD_BACKGROUND;
    assign word_transfer            = hw_command && debug_command_word[`CMD_WORD_BIT];
    assign debug_map_select         = hw_command && debug_command_word[`CMD_MAP_BIT];
    assign debug_map_active         = debug_active_flag ||
                                      (debug_map_select && !enter_background_request);
    assign flow_control_field       = hw_command ? 2'b00 :
                                      debug_command_word[`CMD_FLOW_HI:`CMD_FLOW_LO];
    assign resume_cmd               = flow_control_field == `FLOW_GO;
    assign single_step_cmd          = flow_control_field == `FLOW_STEP;
    assign tag_and_resume_cmd       = flow_control_field == `FLOW_TAG_GO;
    assign target_register_field    = debug_command_word[`CMD_REG_HI:`CMD_REG_LO];
    assign read_write_next          = !hw_command && has_data &&
                                      target_register_field == `REGSEL_NEXT;
    assign select_pc                = !hw_command && has_data &&
                                      target_register_field == `REGSEL_PC;

    assign debug_permit      = debug_status[`ST_PERMIT_BIT];
    assign debug_active_flag = debug_status[`ST_ACTIVE_BIT];
    assign tagging_enable    = debug_status[`ST_TAG_BIT];
    assign shift_valid       = debug_status[`ST_SHIFT_VALID_BIT];
    assign background_grant  = enter_background && debug_permit;
    assign entering          = background_grant && !debug_active_flag;
    // Hardware commands pass without permit; firmware needs active mode.
    assign command_accept    = !tagging_enable &&
                               (hw_command || debug_active_flag);
    assign status_wr         = reg_sel && reg_write && reg_index == 3'd1;

    always @* begin
        next_status = debug_status;
        if (status_wr) begin
            next_status = reg_wdata & `STATUS_WMASK;
        end
        if (shift_load) begin
            next_status[`ST_SHIFT_VALID_BIT] = 1'b0;
        end
        if (shift_done) begin
            next_status[`ST_SHIFT_VALID_BIT] = 1'b1;
        end
        if (exit_background) begin
            next_status[`ST_ACTIVE_BIT] = 1'b0;
        end
        if (debug_active_flag && single_step_cmd) begin
            next_status[`ST_STEP_BIT] = 1'b1;
        end
        if (debug_active_flag && tag_and_resume_cmd) begin
            next_status[`ST_TAG_BIT] = 1'b1;
        end
        // Entry wins over any concurrent write so the active flag is never lost.
        if (entering) begin
            next_status[`ST_ACTIVE_BIT] = 1'b1;
            next_status[`ST_TAG_BIT]    = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            debug_status <= `STATUS_RESET;
        end else begin
            debug_status <= next_status;
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            debug_shift_word      <= 16'h0000;
            debug_address_hold    <= 16'h0000;
            saved_condition_codes <= 8'h00;
        end else begin
            if (shift_load) begin
                debug_shift_word <= shift_in;
            end else if (reg_sel && reg_write && reg_index == 3'd2) begin
                debug_shift_word[15:8] <= reg_wdata;
            end else if (reg_sel && reg_write && reg_index == 3'd3) begin
                debug_shift_word[7:0] <= reg_wdata;
            end
            if (addr_load) begin
                debug_address_hold <= addr_in;
            end
            if (entering) begin
                saved_condition_codes <= cpu_ccr;
            end else if (reg_sel && reg_write && reg_index == 3'd6) begin
                saved_condition_codes <= reg_wdata;
            end
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_sel) begin
            case (reg_index)
                3'd0: reg_rdata <= debug_command_word;
                3'd1: reg_rdata <= debug_status & `STATUS_WMASK;
                3'd2: reg_rdata <= debug_shift_word[15:8];
                3'd3: reg_rdata <= debug_shift_word[7:0];
                3'd4: reg_rdata <= debug_address_hold[15:8];
                3'd5: reg_rdata <= debug_address_hold[7:0];
                3'd6: reg_rdata <= saved_condition_codes;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // Breakpoint comparators, evaluated on every valid bus cycle.
    wire first_addr_hit  = byte_hit(bus_addr[15:8], break_addr_value[15:8], 1'b1) &&
                           byte_hit(bus_addr[7:0], break_addr_value[7:0],
                                    first_low_range_enable);
    wire second_addr_hit = byte_hit(bus_addr[15:8], break_data_value[15:8], 1'b1) &&
                           byte_hit(bus_addr[7:0], break_data_value[7:0],
                                    second_low_range_enable);
    wire data_hit        = byte_hit(bus_data[15:8], break_data_value[15:8],
                                    !high_byte_mask) &&
                           byte_hit(bus_data[7:0], break_data_value[7:0],
                                    !low_byte_mask);
    wire first_dir_hit   = dir_hit(bus_read, direction_match_value,
                                   direction_match_enable);
    wire second_dir_hit  = dir_hit(bus_read, second_direction_value,
                                   second_direction_enable);
    wire tag_only        = program_address_break && bus_fetch;
    reg  next_bg;
    reg  next_swi;
    reg  next_tag;

    always @* begin
        next_bg  = 1'b0;
        next_swi = 1'b0;
        next_tag = 1'b0;
        case (break_mode)
            `MODE_SWI_DUAL: begin
                // Fetch-tagged only; direction and mask controls are ignored.
                next_swi = bus_fetch && (first_addr_hit ||
                           (data_compare_enable && second_addr_hit));
                next_tag = next_swi;
            end
            `MODE_BDM_FULL: begin
                if (program_address_break) begin
                    next_bg = tag_only && first_addr_hit;
                end else begin
                    next_bg = first_addr_hit && first_dir_hit &&
                              (!data_compare_enable || data_hit);
                end
                next_tag = next_bg && program_address_break;
            end
            `MODE_BDM_DUAL: begin
                if (program_address_break) begin
                    next_bg = tag_only && (first_addr_hit ||
                              (data_compare_enable && second_addr_hit));
                end else begin
                    next_bg = (first_addr_hit && first_dir_hit) ||
                              (data_compare_enable && second_addr_hit &&
                               second_dir_hit);
                end
                next_tag = next_bg && program_address_break;
            end
            default: begin
                next_bg = 1'b0;
            end
        endcase
        // No hardware gate on the permit bit; firmware handles that case.
        if (!bus_valid || debug_active_flag) begin
            next_bg  = 1'b0;
            next_swi = 1'b0;
            next_tag = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            break_to_background <= 1'b0;
            break_to_interrupt  <= 1'b0;
            break_tag_fetch     <= 1'b0;
        end else begin
            break_to_background <= next_bg;
            break_to_interrupt  <= next_swi;
            break_tag_fetch     <= next_tag;
        end
    end
endmodule

//--- verification/debug_core_properties.sv
`timescale 1ns/1ps
`include "debug_bkpt_map.vh"
module debug_core_props (
    input wire       clk,
    input wire       reset_n,
    input wire       cmd_load,
    input wire [7:0] cmd_code,
    input wire       shift_done,
    input wire       enter_background,
    input wire       exit_background,
    input wire       reg_sel,
    input wire       reg_write,
    input wire [1:0] break_mode,
    input wire       hw_command,
    input wire       has_data,
    input wire       is_read,
    input wire       enter_background_request,
    input wire       debug_permit,
    input wire       debug_active_flag,
    input wire       tagging_enable,
    input wire       shift_valid,
    input wire       break_to_background,
    input wire       break_to_interrupt,
    input wire       break_tag_fetch
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Tagging blocks serial commands, so loads during tagging prove nothing.
    cmd_fields_a: assert property (cmd_load && !tagging_enable |=>
        ($past(cmd_code) & 8'hE0) == {hw_command, has_data, is_read, 5'h00})
        else $error("command flags do not follow the loaded code");
    background_flag_a: assert property (cmd_load && !tagging_enable &&
        cmd_code == `CMD_BACKGROUND |=> enter_background_request && hw_command)
        else $error("background command not flagged");
    entry_refused_a: assert property (enter_background && !debug_permit &&
        !debug_active_flag && !(reg_sel && reg_write) |=> !debug_active_flag)
        else $error("entry taken without permit");
    entry_grant_a: assert property (enter_background && debug_permit &&
        !exit_background && !(reg_sel && reg_write) |=> debug_active_flag && !tagging_enable)
        else $error("permitted entry not taken");
    no_break_active_a: assert property (debug_active_flag |=>
        !break_to_background && !break_to_interrupt)
        else $error("break fired while active");
    mode_off_a: assert property (break_mode == `MODE_OFF |=>
        !(break_to_background || break_to_interrupt || break_tag_fetch))
        else $error("break fired with breakpoints off");
    swi_only_a: assert property (break_to_interrupt |->
        $past(break_mode) == `MODE_SWI_DUAL)
        else $error("interrupt break outside interrupt mode");
    bdm_only_a: assert property (break_to_background |->
        $past(break_mode) == `MODE_BDM_FULL || $past(break_mode) == `MODE_BDM_DUAL)
        else $error("background break outside debug modes");
    shift_valid_a: assert property (shift_done |=> shift_valid)
        else $error("shift valid not set");
    cover property (break_to_interrupt);
    cover property (break_to_background);
    cover property ($rose(debug_active_flag));
endmodule
bind debug_breakpoint_core debug_core_props i_debug_core_props (.*);

//--- verification/debug_host_model.sv
`timescale 1ns/1ps
module debug_host_model (
    input  wire       clk,
    input  wire       reset_n,
    input  wire       send,
    input  wire       ping,
    input  wire [7:0] code,
    output reg        host_line = 1'b1,
    output reg        cmd_load = 1'b0,
    output reg  [7:0] cmd_code = 8'h00
);
    reg [3:0] cnt = 4'h0;
    reg [7:0] held = 8'h00;
    reg       loading = 1'b0;
    // A released code bus shows the inverse so stale values never match.
    always @(posedge clk) begin
        cmd_load <= 1'b0;
        if (!reset_n) begin
            host_line <= 1'b1;
            cnt <= 4'h0;
        end else if (send || ping) begin
            host_line <= 1'b0;
            cnt <= 4'h8;
            loading <= send;
            held <= code;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
                host_line <= 1'b1;
                cmd_load <= loading;
                cmd_code <= held;
            end
        end else begin
            cmd_code <= ~held;
        end
    end
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
    reg clk = 1'b0, reset_n = 1'b0, shift_load = 1'b0, shift_done = 1'b0, addr_load = 1'b0;
    reg enter_background = 1'b0, exit_background = 1'b0, reg_sel = 1'b0, reg_write = 1'b0;
    reg bus_read = 1'b0, bus_valid = 1'b0, bus_fetch = 1'b0, program_address_break = 1'b0;
    reg first_low_range_enable = 1'b1, second_low_range_enable = 1'b1, send = 1'b0;
    reg data_compare_enable = 1'b1, high_byte_mask = 1'b0, low_byte_mask = 1'b0, ping = 1'b0;
    reg direction_match_value = 1'b1, direction_match_enable = 1'b1;
    reg second_direction_value = 1'b0, second_direction_enable = 1'b0;
    reg [1:0] break_mode = 2'b00;
    reg [2:0] reg_index = 3'h0;
    reg [7:0] cpu_ccr = 8'h00, reg_wdata = 8'h00, code = 8'h00, rd;
    reg [15:0] shift_in = 16'h0000, addr_in = 16'h0000, bus_addr = 16'h0000;
    reg [15:0] bus_data = 16'h0000, break_addr_value = 16'h1234, break_data_value = 16'h5678;
    wire host_line, cmd_load, hw_command, has_data, is_read, enter_background_request;
    wire word_transfer, debug_map_select, resume_cmd, single_step_cmd, tag_and_resume_cmd;
    wire read_write_next, select_pc, debug_map_active, background_grant, command_accept;
    wire debug_permit, debug_active_flag, tagging_enable, shift_valid, break_tag_fetch;
    wire break_to_background, break_to_interrupt;
    wire [1:0] flow_control_field;
    wire [2:0] target_register_field;
    wire [7:0] cmd_code, reg_rdata;
    integer fail_count = 0, checks_done = 0;
    debug_breakpoint_core i_debug_breakpoint_core (.*);
    debug_host_model i_debug_host_model (.*);
    always #5 clk = ~clk;
    task check(input [15:0] got, input [15:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task wr(input [2:0] i, input [7:0] d);
        begin
            @(posedge clk);
            reg_sel <= 1'b1;
            reg_write <= 1'b1;
            reg_index <= i;
            reg_wdata <= d;
            @(posedge clk);
            reg_sel <= 1'b0;
            reg_write <= 1'b0;
        end
    endtask
    task rdchk(input [2:0] i, input [7:0] e);
        begin
            @(posedge clk);
            reg_sel <= 1'b1;
            reg_index <= i;
            @(posedge clk);
            reg_sel <= 1'b0;
            #1 check(reg_rdata, e);
        end
    endtask
    task enter_exit(input x, input g);
        begin
            @(posedge clk);
            enter_background <= !x;
            exit_background <= x;
            #1 check(background_grant, g);
            @(posedge clk);
            enter_background <= 1'b0;
            exit_background <= 1'b0;
        end
    endtask
    task host(input [7:0] c, input p);
        begin
            @(posedge clk);
            code <= c;
            send <= !p;
            ping <= p;
            @(posedge clk);
            send <= 1'b0;
            ping <= 1'b0;
            if (!p) begin
                repeat (20) begin
                    @(posedge clk);
                    #1;
                    if (cmd_load) break;
                end
                @(posedge clk);
                #1;
            end
        end
    endtask
    task test_status;
        begin
            rdchk(3'd1, 8'h00);
            wr(3'd1, 8'h07);
            rdchk(3'd1, 8'h00);
            enter_exit(1'b0, 1'b0);
            rdchk(3'd1, 8'h00);
            @(posedge clk);
            cpu_ccr <= 8'h5A;
            wr(3'd1, 8'hA0);
            enter_exit(1'b0, 1'b1);
            rdchk(3'd1, 8'hC0);
            rdchk(3'd6, 8'h5A);
            wr(3'd6, 8'h33);
            rdchk(3'd6, 8'h33);
            enter_exit(1'b1, 1'b0);
            rdchk(3'd1, 8'h80);
            $display("status test done");
        end
    endtask
    task test_shift;
        begin
            @(posedge clk);
            shift_load <= 1'b1;
            shift_in <= 16'hBEEF;
            addr_load <= 1'b1;
            addr_in <= 16'h1357;
            @(posedge clk);
            shift_load <= 1'b0;
            addr_load <= 1'b0;
            shift_done <= 1'b1;
            #1 check(shift_valid, 1'b0);
            @(posedge clk);
            shift_done <= 1'b0;
            #1 check(shift_valid, 1'b1);
            rdchk(3'd2, 8'hBE);
            rdchk(3'd3, 8'hEF);
            wr(3'd3, 8'h34);
            rdchk(3'd3, 8'h34);
            wr(3'd4, 8'hFF);
            rdchk(3'd4, 8'h13);
            rdchk(3'd5, 8'h57);
            $display("shift test done");
        end
    endtask
    task cmd_case(input [7:0] c);
        begin
            host(c, 1'b0);
            check({hw_command, has_data, is_read}, c[7:5]);
            if (c[7])
                check({enter_background_request, word_transfer, debug_map_select},
                      c[4:2]);
            else
                check({flow_control_field, read_write_next, select_pc},
                      {c[4:3], c[2:0] == 3'b010, c[2:0] == 3'b011});
            check({debug_map_active, command_accept, resume_cmd, single_step_cmd,
                   tag_and_resume_cmd, target_register_field},
                  {c[7] && c[2], c[7], !c[7] && c[4:3] == 2'b01, !c[7] && c[4:3] == 2'b10,
                   !c[7] && c[4:3] == 2'b11, c[2:0]});
            rdchk(3'd0, c);
        end
    endtask
    task brk(input [1:0] m, input [2:0] opt, input r, input f, input [15:0] a, input [15:0] d,
             input [1:0] e);
        begin
            @(posedge clk);
            break_mode <= m;
            program_address_break <= opt[2];
            high_byte_mask <= opt[1];
            second_low_range_enable <= !opt[0];
            bus_valid <= 1'b1;
            bus_read <= r;
            bus_fetch <= f;
            bus_addr <= a;
            bus_data <= d;
            @(posedge clk);
            bus_valid <= 1'b0;
            #1 check({break_to_background, break_to_interrupt}, e);
            check(break_tag_fetch, e[0] || (e[1] && opt[2]));
        end
    endtask
    task test_breaks;
        begin
            brk(2'b00, 3'd0, 1'b1, 1'b1, 16'h1234, 16'h5678, 2'b00);
            brk(2'b01, 3'd0, 1'b0, 1'b1, 16'h1234, 16'h0000, 2'b01);
            brk(2'b01, 3'd0, 1'b1, 1'b0, 16'h1234, 16'h0000, 2'b00);
            brk(2'b01, 3'd1, 1'b1, 1'b1, 16'h56AB, 16'h0000, 2'b01);
            brk(2'b11, 3'd0, 1'b1, 1'b0, 16'h5678, 16'h0000, 2'b10);
            brk(2'b11, 3'd0, 1'b0, 1'b0, 16'h1234, 16'h0000, 2'b00);
            brk(2'b10, 3'd0, 1'b1, 1'b0, 16'h1234, 16'h5678, 2'b10);
            brk(2'b10, 3'd0, 1'b1, 1'b0, 16'h1234, 16'h0078, 2'b00);
            brk(2'b10, 3'd2, 1'b1, 1'b0, 16'h1234, 16'h0078, 2'b10);
            brk(2'b10, 3'd0, 1'b1, 1'b0, 16'h5678, 16'h5678, 2'b00);
            brk(2'b10, 3'd4, 1'b1, 1'b1, 16'h1234, 16'h0000, 2'b10);
            brk(2'b10, 3'd0, 1'b1, 1'b0, 16'h12FF, 16'h5678, 2'b00);
            @(posedge clk);
            data_compare_enable <= 1'b0;
            first_low_range_enable <= 1'b0;
            brk(2'b10, 3'd0, 1'b1, 1'b0, 16'h12FF, 16'h0000, 2'b10);
            brk(2'b01, 3'd1, 1'b1, 1'b1, 16'h56AB, 16'h0000, 2'b00);
            @(posedge clk);
            data_compare_enable <= 1'b1;
            first_low_range_enable <= 1'b1;
            host(8'h10, 1'b0);
            enter_exit(1'b0, 1'b1);
            brk(2'b10, 3'd0, 1'b1, 1'b0, 16'h1234, 16'h5678, 2'b00);
            enter_exit(1'b1, 1'b0);
            rdchk(3'd1, 8'h98);
            $display("breakpoint test done");
        end
    endtask
    task test_timeout;
        begin
            host(8'hC8, 1'b0);
            repeat (400) @(posedge clk);
            host(8'h00, 1'b1);
            repeat (300) @(posedge clk);
            rdchk(3'd0, 8'hC8);
            repeat (600) @(posedge clk);
            rdchk(3'd0, 8'h00);
            $display("timeout test done");
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        test_status;
        test_shift;
        cmd_case(8'h90);
        cmd_case(8'hE4);
        cmd_case(8'hC8);
        cmd_case(8'h62);
        cmd_case(8'h43);
        cmd_case(8'h08);
        cmd_case(8'h10);
        cmd_case(8'h18);
        $display("command test done");
        test_breaks;
        test_timeout;
        stop_test;
    end
    initial begin
        repeat (5000) @(posedge clk);
        fail_count = fail_count + 1;
        stop_test;
    end
endmodule
